// File: hdl/ehc_pkg.sv
// ehc_pkg: constants shared by the header comparator and its flow slots
// assumes a single 40 mhz clock domain and a 32-bit apb register bus
package ehc_pkg;
    // ********************
    // clock and timing
    // ********************
    localparam int CLK_MHZ = 40;
    localparam int RESULT_LATENCY = 2; // edges from last captured byte to result
    // ********************
    // register byte offsets (apb)
    // ********************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TPID = 8'h04;
    localparam logic [7:0] OFS_TYPE = 8'h08;
    localparam logic [7:0] OFS_FLOW = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // ********************
    // control register field positions
    // ********************
    localparam int CTRL_NEXT_LSB = 0;
    localparam int CTRL_SIG_LSB = 8;
    localparam int CTRL_BB_BIT = 16;
    localparam int CTRL_TCE_BIT = 17;
    localparam int CTRL_MODE_BIT = 18;
    localparam int TYPE_MASK_LSB = 16;
    localparam int FLOW_TAGS_LSB = 8;
    // ********************
    // reset values
    // ********************
    localparam logic [2:0] RST_NEXT_STAGE = 3'h1;
    localparam logic [4:0] RST_SIG_OFFSET = 5'h00;
    localparam logic [15:0] RST_SERVICE_TPID = 16'h8a88;
    localparam logic [15:0] RST_TYPE_VALUE = 16'h0000;
    localparam logic [15:0] RST_TYPE_MASK = 16'hffff;
    localparam logic [7:0] RST_FLOW_ENABLE = 8'h00;
    localparam logic [15:0] RST_FLOW_TAGS = 16'h0000;
    // ********************
    // header encodings and lengths
    // ********************
    localparam logic [15:0] CUST_TAG_TPID = 16'h8100;
    localparam logic [15:0] ITAG_TPID = 16'h88e7;
    localparam logic [15:0] LENGTH_LIMIT = 16'h0600;
    localparam logic [7:0] LLC_SAP_A = 8'haa;
    localparam logic [7:0] LLC_SAP_B = 8'hab;
    localparam logic [7:0] LLC_CONTROL = 8'h03;
    localparam logic [23:0] OUI_ZERO = 24'h000000;
    localparam logic [23:0] OUI_ALT = 24'h0000f8;
    localparam int HDR_MAX = 36;
    localparam logic [5:0] HDR_MAX_W = 6'h24;
    localparam logic [5:0] ADDR_LEN = 6'h0c;
    localparam logic [5:0] TAG_LEN = 6'h04;
    localparam logic [5:0] ITAG_LEN = 6'h06;
    localparam logic [5:0] TYPE_LEN = 6'h02;
    localparam logic [5:0] LLC_SNAP_LEN = 6'h0a;
    localparam logic [5:0] LLC_OFS = 6'h02;
    localparam logic [5:0] OUI_OFS = 6'h05;
    localparam logic [5:0] SNAP_TYPE_OFS = 6'h08;
    localparam int FLOWS = 8;
endpackage : ehc_pkg

// File: hdl/ehc_flow_slot.sv
// ehc_flow_slot: one flow of the comparator's flow check
// assumes tag count comes from the parent's registered parse result
`timescale 1ns/1ps
module ehc_flow_slot (
    input wire logic enable,
    input wire logic [1:0] want_tags,
    input wire logic [1:0] seen_tags,
    output logic hit
);
    import ehc_pkg::*;
    // a disabled slot never hits, so unused flows cost nothing
    assign hit = enable && (want_tags == seen_tags);
endmodule : ehc_flow_slot

// File: hdl/ehc_comparator.sv
// ehc_comparator: ethernet/llc/snap header comparator stage of an analyzer engine
// assumes header bytes arrive at most one per clock, qualified by hdr_valid, from the engine controller, byte 0 first,
// and an apb master on the same 40 mhz clock.
//
// What this block does
// - each engine holds two such stages; the first stage is always one
// - second stage may sit anywhere in the chain via configuration
// - accepts ethertype and length+llc+snap forms, each with 0-2 vlan tags
// - type ii tags recognised as s-tag (programmable, 0x8a88) or c-tag 0x8100
// - llc valid when both saps are 0xaa or 0xab and control is 0x03
// - snap follows llc: 3-octet oui then 2-octet ethertype
// - snap oui compared only against fixed zero or 0xf8
// - snap ethertype equal to a vlan id means a vlan tag follows
// - longest header two tags plus llc plus snap gives correct next offset
// - backbone frames use both stages back to back, first takes outer header
// - outer backbone header is type ii with 0 or 1 tag then i-tag
// - one shared next-protocol register set checks the next protocol
// - separate flow check matches when any configured flow matches
// - next-protocol check uses the last ethertype, earlier tag ids skipped
// - examined fields checked by pattern and mask, each with an offset; here only the last ethertype is checked, with no offset
// - 3-bit field names the next comparator
// - 5-bit field gives start of the frame signature field
// - one 16-bit tpid value recognises s-tags, b-tags and other non c/i tags
// - backbone enable exists only in the first stage, off in the second
// - type check enable acts only on type ii frames
// - enabled type ii ethertype compared with programmed value, mismatch fails
// - mask bit one compares, mask bit zero is a wildcard
// - no valid match signals no-modify so the time stamp is dropped
// - type below 0x0600 is a length needing llc and snap, else ethertype
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module ehc_comparator #(
    parameter bit IS_FIRST = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // header byte stream from the engine controller
    input wire logic hdr_valid,
    input wire logic hdr_first,
    input wire logic hdr_last,
    input wire logic [7:0] hdr_byte,
    // result to the engine controller
    output logic res_valid,
    output logic res_match,
    output logic res_flow_match,
    output logic [5:0] res_offset,
    output logic [2:0] res_next_stage,
    output logic [4:0] res_sig_offset,
    output logic no_modify_indication
);
    import ehc_pkg::*;

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [2:0] next_stage_pointer;
    logic [4:0] signature_field_offset;
    logic [15:0] service_tag_protocol_id;
    logic backbone_bridging_enable;
    logic type_check_enable;
    logic ethertype_mode;
    logic [15:0] type_check_value;
    logic [15:0] type_check_mask;
    logic [7:0] flow_enable;
    logic [15:0] flow_tags;
    logic [31:0] status_word;

    logic wr_take;
    logic setup;
    logic addr_ok;
    logic [31:0] rd_word;

    assign setup = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_TPID) || (paddr == OFS_TYPE)
        || (paddr == OFS_FLOW) || (paddr == OFS_STATUS);

    // one shared set for every flow of this stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            next_stage_pointer <= RST_NEXT_STAGE;
            signature_field_offset <= RST_SIG_OFFSET;
            backbone_bridging_enable <= 1'b0;
            type_check_enable <= 1'b0;
            ethertype_mode <= 1'b0;
            service_tag_protocol_id <= RST_SERVICE_TPID;
            type_check_value <= RST_TYPE_VALUE;
            type_check_mask <= RST_TYPE_MASK;
            flow_enable <= RST_FLOW_ENABLE;
            flow_tags <= RST_FLOW_TAGS;
        end else if (wr_take && !pslverr) begin
            case (paddr)
                OFS_CTRL: begin
                    next_stage_pointer <= pwdata[CTRL_NEXT_LSB +: 3];
                    signature_field_offset <= pwdata[CTRL_SIG_LSB +: 5];
                    // second stage has no backbone parsing, the bit stays zero
                    backbone_bridging_enable <= IS_FIRST && pwdata[CTRL_BB_BIT];
                    type_check_enable <= pwdata[CTRL_TCE_BIT];
                    ethertype_mode <= pwdata[CTRL_MODE_BIT];
                end
                OFS_TPID: begin
                    service_tag_protocol_id <= pwdata[15:0];
                end
                OFS_TYPE: begin
                    type_check_value <= pwdata[15:0];
                    type_check_mask <= pwdata[TYPE_MASK_LSB +: 16];
                end
                OFS_FLOW: begin
                    flow_enable <= pwdata[7:0];
                    flow_tags <= pwdata[FLOW_TAGS_LSB +: 16];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: begin
                rd_word[CTRL_NEXT_LSB +: 3] = next_stage_pointer;
                rd_word[CTRL_SIG_LSB +: 5] = signature_field_offset;
                rd_word[CTRL_BB_BIT] = backbone_bridging_enable;
                rd_word[CTRL_TCE_BIT] = type_check_enable;
                rd_word[CTRL_MODE_BIT] = ethertype_mode;
            end
            OFS_TPID: rd_word[15:0] = service_tag_protocol_id;
            OFS_TYPE: rd_word = {type_check_mask, type_check_value};
            OFS_FLOW: rd_word[23:0] = {flow_tags, flow_enable};
            OFS_STATUS: rd_word = status_word;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // zero-wait slave: answer prepared in setup so prdata comes from a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_ok;
            if (setup) begin
                prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // ************************************************************
    // header capture
    // ************************************************************
    logic [7:0] hbuf [0:HDR_MAX-1];
    logic [5:0] cap_cnt;
    logic [5:0] cap_len;
    logic capturing;
    logic cap_done;
    logic take_byte;

    // byte 0 is the first byte of this protocol
    assign take_byte = hdr_valid && (hdr_first || capturing);

    always_ff @(posedge clk) begin
        if (take_byte) begin
            hbuf[hdr_first ? 6'h00 : cap_cnt] <= hdr_byte;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cap_cnt <= 6'h00;
            cap_len <= 6'h00;
            capturing <= 1'b0;
            cap_done <= 1'b0;
        end else begin
            cap_done <= 1'b0;
            if (take_byte) begin
                if (hdr_first) begin
                    cap_cnt <= 6'h01;
                end else begin
                    cap_cnt <= cap_cnt + 6'h01;
                end
                if (hdr_last || (!hdr_first && cap_cnt == HDR_MAX_W - 6'h01)) begin
                    capturing <= 1'b0;
                    cap_done <= 1'b1;
                    cap_len <= hdr_first ? 6'h01 : cap_cnt + 6'h01;
                end else begin
                    capturing <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // header parse
    // ************************************************************
    function automatic logic [15:0] be16(input logic [5:0] idx);
        be16 = {hbuf[idx], hbuf[idx + 6'h01]};
    endfunction

    function automatic logic is_tag(input logic [15:0] tpid, input logic [15:0] stpid);
        is_tag = (tpid == CUST_TAG_TPID) || (tpid == stpid);
    endfunction

    logic [5:0] pos;
    logic [1:0] tags;
    logic [15:0] last_type;
    logic [15:0] snap_type;
    logic form_ok;
    logic type2;
    logic llc_seen;
    logic snap_seen;
    logic pbb_seen;

    always_comb begin
        pos = ADDR_LEN;
        tags = 2'h0;
        last_type = 16'h0000;
        snap_type = 16'h0000;
        form_ok = 1'b1;
        type2 = 1'b0;
        llc_seen = 1'b0;
        snap_seen = 1'b0;
        pbb_seen = 1'b0;
        if (IS_FIRST && backbone_bridging_enable) begin
            // outer header: optional b-tag, then mandatory i-tag
            if (be16(pos) == service_tag_protocol_id) begin
                pos = pos + TAG_LEN;
                tags = 2'h1;
            end
            if (be16(pos) == ITAG_TPID) begin
                last_type = ITAG_TPID;
                pos = pos + ITAG_LEN;
                pbb_seen = 1'b1;
            end else begin
                form_ok = 1'b0;
            end
        end else begin
            // earlier tag ids are stepped over, only the last type counts
            for (int i = 0; i < 2; i++) begin
                if (tags == 2'(i) && is_tag(be16(pos), service_tag_protocol_id)) begin
                    pos = pos + TAG_LEN;
                    tags = tags + 2'h1;
                end
            end
            last_type = be16(pos);
            if (last_type < LENGTH_LIMIT) begin
                form_ok = ethertype_mode;
                llc_seen = ((hbuf[pos + LLC_OFS] == LLC_SAP_A)
                    || (hbuf[pos + LLC_OFS] == LLC_SAP_B))
                    && ((hbuf[pos + LLC_OFS + 6'h01] == LLC_SAP_A)
                    || (hbuf[pos + LLC_OFS + 6'h01] == LLC_SAP_B))
                    && (hbuf[pos + LLC_OFS + 6'h02] == LLC_CONTROL);
                snap_seen = llc_seen && (({hbuf[pos + OUI_OFS], hbuf[pos + OUI_OFS + 6'h01],
                    hbuf[pos + OUI_OFS + 6'h02]} == OUI_ZERO)
                    || ({hbuf[pos + OUI_OFS], hbuf[pos + OUI_OFS + 6'h01],
                    hbuf[pos + OUI_OFS + 6'h02]} == OUI_ALT));
                if (!snap_seen) begin
                    form_ok = 1'b0;
                end
                snap_type = be16(pos + SNAP_TYPE_OFS);
                last_type = snap_type;
                pos = pos + LLC_SNAP_LEN;
                if (is_tag(snap_type, service_tag_protocol_id)) begin
                    // tag control word, then the ethertype that ends the header
                    last_type = be16(pos + TYPE_LEN);
                    pos = pos + TAG_LEN;
                end
            end else begin
                type2 = 1'b1;
                pos = pos + TYPE_LEN;
            end
        end
        // a header running past the captured bytes cannot match
        if (pos > cap_len) begin
            form_ok = 1'b0;
        end
    end

    // ************************************************************
    // stage 1: register the parse
    // ************************************************************
    logic s1_valid;
    logic s1_form_ok;
    logic s1_type2;
    logic [5:0] s1_pos;
    logic [1:0] s1_tags;
    logic [15:0] s1_type;
    logic s1_llc;
    logic s1_snap;
    logic s1_pbb;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_valid <= 1'b0;
            s1_form_ok <= 1'b0;
            s1_type2 <= 1'b0;
            s1_pos <= 6'h00;
            s1_tags <= 2'h0;
            s1_type <= 16'h0000;
            s1_llc <= 1'b0;
            s1_snap <= 1'b0;
            s1_pbb <= 1'b0;
        end else begin
            s1_valid <= cap_done;
            if (cap_done) begin
                s1_form_ok <= form_ok;
                s1_type2 <= type2;
                s1_pos <= pos;
                s1_tags <= tags;
                s1_type <= last_type;
                s1_llc <= llc_seen;
                s1_snap <= snap_seen;
                s1_pbb <= pbb_seen;
            end
        end
    end

    // ************************************************************
    // stage 2: next-protocol and flow checks
    // ************************************************************
    logic type_fail;
    logic [FLOWS-1:0] flow_hit;
    logic flow_any;
    logic proto_ok;

    // mask bit one compares, zero is a wildcard; only type ii frames are checked
    assign type_fail = s1_type2 && type_check_enable
        && (((s1_type ^ type_check_value) & type_check_mask) != 16'h0000);

    genvar g;
    generate
        for (g = 0; g < FLOWS; g++) begin : g_flow
            ehc_flow_slot u_slot (
                .enable(flow_enable[g]),
                .want_tags(flow_tags[2*g +: 2]),
                .seen_tags(s1_tags),
                .hit(flow_hit[g])
            );
        end
    endgenerate

    assign flow_any = |flow_hit;
    assign proto_ok = s1_form_ok && !type_fail;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_valid <= 1'b0;
            res_match <= 1'b0;
            res_flow_match <= 1'b0;
            res_offset <= 6'h00;
            res_next_stage <= RST_NEXT_STAGE;
            res_sig_offset <= RST_SIG_OFFSET;
            no_modify_indication <= 1'b0;
        end else begin
            res_valid <= s1_valid;
            no_modify_indication <= 1'b0;
            if (s1_valid) begin
                res_match <= proto_ok && flow_any;
                res_flow_match <= flow_any;
                res_offset <= s1_pos;
                res_next_stage <= next_stage_pointer;
                res_sig_offset <= signature_field_offset;
                // the time stamp logic drops the stamp on this pulse
                no_modify_indication <= !(proto_ok && flow_any);
            end
        end
    end

    // ************************************************************
    // status capture
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_word <= 32'h0000_0000;
        end else if (s1_valid) begin
            status_word <= {s1_type, 3'h0, s1_pbb, s1_snap, s1_llc, s1_tags,
                s1_pos, flow_any, proto_ok && flow_any};
        end
    end
endmodule : ehc_comparator

// File: testbench/ehc_comparator_sva.sv
// ehc_comparator_sva: port-level checks of the header comparator
// assumes one clock domain and the async active-high reset of the top
`timescale 1ns/1ps
module ehc_comparator_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hdr_valid,
    input wire logic hdr_first,
    input wire logic hdr_last,
    input wire logic res_valid,
    input wire logic res_match,
    input wire logic res_flow_match,
    input wire logic [5:0] res_offset,
    input wire logic no_modify_indication
);
    // ********************
    // capture tracking: marks the edge that ends a header
    // ********************
    logic [5:0] cnt, idx;
    logic cap, e0, e0_d1, e0_d2, e0_d3;
    assign idx = hdr_first ? 6'h00 : cnt;
    assign e0 = hdr_valid && (hdr_first || cap) && (hdr_last || idx == 6'h23);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cap <= 1'b0;
            cnt <= 6'h00;
            e0_d1 <= 1'b0;
            e0_d2 <= 1'b0;
            e0_d3 <= 1'b0;
        end else begin
            e0_d1 <= e0;
            e0_d2 <= e0_d1;
            e0_d3 <= e0_d2;
            if (hdr_valid && (hdr_first || cap)) begin
                cap <= !e0;
                cnt <= idx + 6'h01;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_map: assert property (pready |->
        pslverr == (paddr[1:0] != 2'h0 || paddr[7:2] > 6'h04))
        else $error("bad error flag");
    a_result_latency: assert property (e0 |-> ##3 res_valid)
        else $error("result late");
    a_result_cause: assert property (res_valid |-> e0_d3)
        else $error("result without header end");
    a_nomod_needed: assert property (res_valid && !res_match |-> no_modify_indication)
        else $error("missing no-modify");
    a_nomod_cause: assert property (no_modify_indication |-> res_valid && !res_match)
        else $error("spurious no-modify");
    a_match_flow: assert property (res_match |-> res_flow_match)
        else $error("match without flow hit");
    a_offset_hold: assert property (!$stable(res_offset) |-> res_valid)
        else $error("offset changed between results");
endmodule : ehc_comparator_sva

bind ehc_comparator ehc_comparator_sva u_sva (.*);

// File: testbench/ehc_engine_model.sv
// ehc_engine_model: engine controller streaming one header, byte 0 first
// assumes frame is right-aligned, len bytes long; slow inserts idle gaps
`timescale 1ns/1ps
module ehc_engine_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic slow,
    input wire logic [5:0] len,
    input wire logic [287:0] frame,
    output logic hdr_valid,
    output logic hdr_first,
    output logic hdr_last,
    output logic [7:0] hdr_byte
);
    // ********************
    // byte stream
    // ********************
    logic busy, gap;
    logic [5:0] idx;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            gap <= 1'b0;
            idx <= 6'h00;
            hdr_valid <= 1'b0;
            hdr_first <= 1'b0;
            hdr_last <= 1'b0;
            hdr_byte <= 8'h00;
        end else if (start) begin
            busy <= 1'b1;
            idx <= 6'h00;
        end else if (busy && !(slow && gap)) begin
            hdr_valid <= 1'b1;
            hdr_first <= idx == 6'h00;
            hdr_last <= idx == len - 6'h01;
            hdr_byte <= frame[8 * (len - 6'h01 - idx) +: 8];
            idx <= idx + 6'h01;
            busy <= idx != len - 6'h01;
            gap <= 1'b1;
        end else begin
            // idle byte lane toggles so a stale value is never mistaken for data
            hdr_valid <= 1'b0;
            hdr_first <= 1'b0;
            hdr_last <= 1'b0;
            hdr_byte <= ~hdr_byte;
            gap <= 1'b0;
        end
    end
endmodule : ehc_engine_model

// File: testbench/ehc_comparator_tb.sv
// ehc_comparator_tb: self-checking bench of the header comparator
// assumes first-stage instance, apb master here, engine model on the header side
`timescale 1ns/1ps
module ehc_comparator_tb;
    import ehc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, hdr_valid, hdr_first, hdr_last, errv;
    logic [7:0] hdr_byte;
    logic res_valid, res_match, res_flow_match, no_modify_indication;
    logic [5:0] res_offset;
    logic [2:0] res_next_stage;
    logic [4:0] res_sig_offset;
    logic start = 1'b0, slow = 1'b0;
    logic [5:0] flen = 6'h01;
    logic [287:0] frm = '0;
    int failures = 0, check_count = 0, cycles = 0;
    always #12.5 clk = ~clk;
    ehc_comparator u_dut (.*);
    ehc_engine_model u_eng (.*, .len(flen), .frame(frm));
    // ********************
    // shared tasks
    // ********************
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only pready or the bench timeout ends this wait
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        check(rdv, exp);
        check({31'h0, errv}, {31'h0, exp_err});
    endtask : rd_chk
    task automatic run(input logic [287:0] f, input logic [5:0] len, input logic em,
                       input logic [5:0] eo);
        int n;
        @(posedge clk);
        start <= 1'b1;
        flen <= len;
        frm <= f;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (res_valid !== 1'b1 && n < 200);
        check({31'h0, res_valid}, 32'h1);
        check({31'h0, res_match}, {31'h0, em});
        check({31'h0, no_modify_indication}, {31'h0, !em});
        if (em) begin
            check({26'h0, res_offset}, {26'h0, eo});
        end
    endtask : run
    // ********************
    // scenarios
    // ********************
    task automatic t_regs();
        rd_chk(OFS_CTRL, 32'h00000001, 1'b0);
        rd_chk(OFS_TPID, 32'h00008a88, 1'b0);
        rd_chk(OFS_TYPE, 32'hffff0000, 1'b0);
        rd_chk(8'h14, 32'h0, 1'b1);
        wr(OFS_CTRL, 32'h00011f06);
        rd_chk(OFS_CTRL, 32'h00011f06, 1'b0);
        wr(OFS_CTRL, 32'h00000002);
        wr(OFS_FLOW, 32'h00002407);
        $display("registers done");
    endtask : t_regs
    task automatic t_type2();
        run({16'h88f7}, 6'd14, 1'b1, 6'd14);
        check({29'h0, res_next_stage}, 32'h2);
        wr(OFS_CTRL, 32'h00021502);
        wr(OFS_TYPE, 32'hffff88f7);
        run({16'h88f7}, 6'd14, 1'b1, 6'd14);
        check({27'h0, res_sig_offset}, 32'h15);
        wr(OFS_TYPE, 32'hffff0800);
        run({16'h88f7}, 6'd14, 1'b0, 6'd0);
        wr(OFS_TYPE, 32'hff008812);
        run({16'h88f7}, 6'd14, 1'b1, 6'd14);
        wr(OFS_CTRL, 32'h00000002);
        $display("type ii done");
    endtask : t_type2
    task automatic t_tags();
        slow <= 1'b1;
        run({32'h81000005, 32'h8a880006, 16'h88f7}, 6'd22, 1'b1, 6'd22);
        slow <= 1'b0;
        wr(OFS_TPID, 32'h00009100);
        run({32'h91000001, 16'h88f7}, 6'd18, 1'b1, 6'd18);
        run({32'h8a880001, 16'h88f7}, 6'd18, 1'b1, 6'd14);
        $display("tags done");
    endtask : t_tags
    task automatic t_llc();
        wr(OFS_CTRL, 32'h00060002);
        wr(OFS_TYPE, 32'hffff1234);
        run({32'h81000001, 32'h91000002, 16'h0040, 24'haaaa03, 24'h0, 16'h88f7},
            6'd30, 1'b1, 6'd30);
        run({16'h0040, 24'habab03, 24'h0000f8, 16'h88f7}, 6'd22, 1'b1, 6'd22);
        run({16'h0040, 24'haaaa04, 24'h0, 16'h88f7}, 6'd22, 1'b0, 6'd0);
        run({16'h0040, 24'haaaa03, 24'h000001, 16'h88f7}, 6'd22, 1'b0, 6'd0);
        run({16'h0040, 24'haaaa03, 24'h0, 16'h8100, 16'h0007, 16'h88f7},
            6'd26, 1'b1, 6'd26);
        wr(OFS_CTRL, 32'h00000002);
        run({16'h0040, 24'haaaa03, 24'h0, 16'h88f7}, 6'd22, 1'b0, 6'd0);
        $display("llc snap done");
    endtask : t_llc
    task automatic t_flow();
        wr(OFS_FLOW, 32'h00000000);
        run({16'h88f7}, 6'd14, 1'b0, 6'd0);
        check({31'h0, res_flow_match}, 32'h0);
        wr(OFS_FLOW, 32'h00004008);
        run({32'h81000001, 16'h88f7}, 6'd18, 1'b1, 6'd18);
        run({16'h88f7}, 6'd14, 1'b0, 6'd0);
        $display("flows done");
    endtask : t_flow
    task automatic t_backbone();
        wr(OFS_TPID, 32'h00008a88);
        wr(OFS_FLOW, 32'h00002407);
        wr(OFS_CTRL, 32'h00010002);
        run({16'h88e7, 32'h00000001}, 6'd18, 1'b1, 6'd18);
        run({32'h8a880003, 16'h88e7, 32'h00000001}, 6'd22, 1'b1, 6'd22);
        rd_chk(OFS_STATUS, 32'h88e7115b, 1'b0);
        $display("backbone done");
    endtask : t_backbone
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_type2();
        t_tags();
        t_llc();
        t_flow();
        t_backbone();
        summarize();
    end
endmodule : ehc_comparator_tb
